// file: evs_pkg.sv
/*
  Package for the excitation voltage supervision block: fixed-point formats,
  per-unit limits, setting defaults, timing constants and carrier structs.
  Assumes all per-unit inputs share one signed format with 0.005 p.u. per LSB
  scaled by EVS_PU_ONE (value = code / 200), and a 100 MHz system clock.
*/
package evs_pkg;

  // Signed per-unit quantities: 1 LSB = 0.005 p.u., range about +-655 p.u.
  localparam int EVS_PU_W = 18;
  localparam int EVS_PU_ONE = 200;
  // Ratio settings: 1 LSB = 0.005, range 0..10 (2000 codes)
  localparam int EVS_RATIO_W = 12;
  localparam int EVS_RATIO_ONE = 200;
  // Control signal threshold: 1 LSB = 0.01, range 0..25 (2500 codes)
  localparam int EVS_CTRL_W = 12;

  localparam logic signed [EVS_PU_W-1:0] EVS_PU_0P1 = 18'sh00014;
  localparam logic signed [EVS_PU_W-1:0] EVS_PU_0P2 = 18'sh00028;
  localparam logic signed [EVS_PU_W-1:0] EVS_PU_M0P2 = -18'sh00028;

  localparam logic [EVS_RATIO_W-1:0] EVS_VOLT_RATIO_DEF = 12'h03c;
  localparam logic [EVS_RATIO_W-1:0] EVS_CURR_RATIO_DEF = 12'h03c;
  localparam logic [EVS_RATIO_W-1:0] EVS_FIELD_LEVEL_DEF = 12'h0c8;
  localparam logic [EVS_CTRL_W-1:0] EVS_SHORT_THR_DEF = 12'h064;

  // Delays are counted in 5 ms steps
  localparam int EVS_STEP_NS = 5000000;
  localparam int EVS_CLK_NS = 10;
  localparam int EVS_STEP_CYCLES = EVS_STEP_NS / EVS_CLK_NS;
  localparam int EVS_DLY_W = 12;
  localparam logic [EVS_DLY_W-1:0] EVS_VOLT_DLY_DEF = 12'h028;
  localparam logic [EVS_DLY_W-1:0] EVS_OVC_DLY_DEF = 12'h258;

  typedef struct packed {
    logic signed [EVS_PU_W-1:0] pos_volt;
    logic signed [EVS_PU_W-1:0] neg_volt;
    logic signed [EVS_PU_W-1:0] pos_curr;
    logic signed [EVS_PU_W-1:0] neg_curr;
    logic signed [EVS_PU_W-1:0] supply_volt;
    logic signed [EVS_PU_W-1:0] field_curr;
  } evs_meas_type;

  typedef struct packed {
    logic supv_enable;
    logic [EVS_DLY_W-1:0] volt_delay;
    logic [EVS_RATIO_W-1:0] volt_high_ratio;
    logic [EVS_RATIO_W-1:0] curr_low_ratio;
    logic [EVS_RATIO_W-1:0] field_level;
    logic ovc_enable;
    logic [EVS_CTRL_W-1:0] short_thr;
    logic [EVS_DLY_W-1:0] ovc_delay;
  } evs_cfg_type;

  typedef enum logic [1:0] {
    EVS_T_IDLE = 2'b00,
    EVS_T_RUN = 2'b01,
    EVS_T_TRIP = 2'b10
  } evs_tstate_type;

endpackage : evs_pkg

// file: evs_tick.sv
/*
  Step divider: one-cycle enable pulse every STEP_CYCLES system clocks.
  Assumes a single free-running sys_clk.
*/
`timescale 1ns/1ps
module evs_tick
  import evs_pkg::*;
#(
  parameter int STEP_CYCLES = EVS_STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic tick
);
  logic [19:0] cnt_reg;
  wire cnt_wrap = (cnt_reg == 20'(STEP_CYCLES - 1));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_reg <= 20'h00000;
      tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_wrap ? 20'h00000 : cnt_reg + 20'h00001;
      tick <= cnt_wrap;
    end
  end
endmodule : evs_tick

// file: evs_delay.sv
/*
  Delay timer: raises trip once start has held for delay steps.
  Assumes tick is a one-cycle pulse per step from evs_tick.
*/
`timescale 1ns/1ps
module evs_delay
  import evs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic start,
  input wire logic [EVS_DLY_W-1:0] delay,
  output logic trip
);
  evs_tstate_type state_reg;
  evs_tstate_type state_next;
  logic [EVS_DLY_W-1:0] cnt_reg;
  logic [EVS_DLY_W-1:0] cnt_next;
  wire done = (cnt_reg >= delay);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      EVS_T_IDLE: begin
        cnt_next = '0;
        if (start) begin
          state_next = (delay == '0) ? EVS_T_TRIP : EVS_T_RUN;
        end
      end
      EVS_T_RUN: begin
        if (!start) begin
          // A dropout before expiry forgets all progress
          state_next = EVS_T_IDLE;
          cnt_next = '0;
        end else if (done) begin
          state_next = EVS_T_TRIP;
        end else if (tick) begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      EVS_T_TRIP: begin
        if (!start) begin
          state_next = EVS_T_IDLE;
          cnt_next = '0;
        end
      end
      default: begin
        state_next = EVS_T_IDLE;
        cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= EVS_T_IDLE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  assign trip = (state_reg == EVS_T_TRIP) && start;
endmodule : evs_delay

// file: evs_supervision.sv
/*
  Excitation voltage supervision: phase loss and differential checks on
  the generator measuring voltage and excitation supply voltage, a delayed
  changeover request to field current regulation, and shorted-switch
  field overcurrent detection.
  Assumes measurements arrive synchronous to sys_clk in evs_pkg formats and
  that settings are held stable by the surrounding controller.
*/
`timescale 1ns/1ps

module evs_supervision
  import evs_pkg::*;
#(
  parameter int STEP_CYCLES = EVS_STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire evs_meas_type meas,
  input wire logic signed [EVS_CTRL_W:0] ctrl_signal,
  input wire logic volt_synced,
  input wire logic on_grid,
  input wire logic field_limiter_active,
  input wire evs_cfg_type cfg,
  input wire logic cfg_load,
  output logic voltage_regulation_mode,
  output logic field_current_regulation_mode,
  output logic meas_volt_low,
  output logic supply_volt_low,
  output logic phase_loss,
  output logic grid_disturbance,
  output logic volt_trip,
  output logic ovc_detect,
  output logic ovc_trip,
  output logic signed [EVS_PU_W-1:0] positive_sequence_gen_voltage,
  output logic signed [EVS_PU_W-1:0] negative_sequence_gen_voltage,
  output logic signed [EVS_PU_W-1:0] supply_volt_disp,
  output evs_cfg_type cfg_active
);
  localparam int PW = EVS_PU_W + EVS_RATIO_W + 2;

  // Signed product of a per-unit value and an unsigned ratio code
  function automatic logic signed [PW-1:0] scale(
    input logic signed [EVS_PU_W-1:0] v,
    input logic [EVS_RATIO_W-1:0] r
  );
    logic signed [PW-1:0] a;
    logic signed [PW-1:0] b;
    a = PW'(v);
    b = $signed({2'b00, {EVS_PU_W{1'b0}}, r});
    return PW'(a * b);
  endfunction : scale

  // Multiplier by EVS_RATIO_ONE puts the left side in ratio units
  function automatic logic signed [PW-1:0] unity(
    input logic signed [EVS_PU_W-1:0] v
  );
    return scale(v, EVS_RATIO_W'(EVS_RATIO_ONE));
  endfunction : unity

  logic supv_en_reg;
  logic ovc_en_reg;
  evs_cfg_type cfg_reg;
  evs_cfg_type cfg_next;

  // Settings latch: defaults after reset, new values on cfg_load
  always_comb begin
    cfg_next = cfg_reg;
    if (cfg_load) begin
      cfg_next = cfg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_reg.supv_enable <= 1'b1;
      cfg_reg.volt_delay <= EVS_VOLT_DLY_DEF;
      cfg_reg.volt_high_ratio <= EVS_VOLT_RATIO_DEF;
      cfg_reg.curr_low_ratio <= EVS_CURR_RATIO_DEF;
      cfg_reg.field_level <= EVS_FIELD_LEVEL_DEF;
      cfg_reg.ovc_enable <= 1'b0;
      cfg_reg.short_thr <= EVS_SHORT_THR_DEF;
      cfg_reg.ovc_delay <= EVS_OVC_DLY_DEF;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign supv_en_reg = cfg_reg.supv_enable;
  assign ovc_en_reg = cfg_reg.ovc_enable;

  // Sequence-component comparisons, no division except in the field_high threshold
  wire logic signed [PW-1:0] nsv_x2 = PW'(meas.neg_volt) <<< 1;
  wire logic signed [PW-1:0] psv_ext = PW'(meas.pos_volt);
  wire logic signed [PW-1:0] i2_x2 = PW'(meas.neg_curr) <<< 1;
  wire logic signed [PW-1:0] i1_ext = PW'(meas.pos_curr);
  wire logic phase_loss_w = (nsv_x2 > psv_ext);
  wire logic disturb_w = (i2_x2 > i1_ext);

  wire logic volt_ratio_high =
    unity(meas.neg_volt) > scale(meas.pos_volt, cfg_reg.volt_high_ratio);
  wire logic curr_ratio_low =
    unity(meas.neg_curr) < scale(meas.pos_curr, cfg_reg.curr_low_ratio);
  wire logic psv_above = meas.pos_volt > EVS_PU_0P1;
  wire logic psv_below = meas.pos_volt < EVS_PU_0P1;
  wire logic i1_below = meas.pos_curr < EVS_PU_0P1;
  wire logic field_high = unity(meas.field_curr) >
    PW'($signed({1'b0, cfg_reg.field_level})) * PW'(EVS_PU_ONE) /
    PW'(EVS_RATIO_ONE) * PW'(EVS_RATIO_ONE);

  wire logic signed [EVS_PU_W:0] diff_volt =
    (EVS_PU_W+1)'(meas.pos_volt) - (EVS_PU_W+1)'(meas.supply_volt);
  wire logic diff_high = diff_volt > (EVS_PU_W+1)'(EVS_PU_0P2);
  wire logic diff_low = diff_volt < (EVS_PU_W+1)'(EVS_PU_M0P2);

  wire logic route1 = volt_synced && volt_ratio_high && psv_above &&
    (curr_ratio_low || i1_below);
  wire logic route2 = psv_below && field_high;
  wire logic route3 = on_grid && diff_low;

  // Supervision gated by master enable and grid-disturbance block
  wire logic supv_ok = supv_en_reg && !disturb_w;
  wire logic meas_low_w = supv_ok && (route1 || route2 || route3 ||
    phase_loss_w);
  wire logic supply_low_w = supv_ok && on_grid && diff_high;
  wire logic volt_start = meas_low_w || supply_low_w;

  // Field overcurrent: only meaningful while the instant limiter holds current
  wire logic signed [EVS_CTRL_W:0] thr_ext =
    $signed({1'b0, cfg_reg.short_thr});
  wire logic ovc_w = ovc_en_reg && field_limiter_active &&
    (ctrl_signal < thr_ext);

  logic tick;
  logic volt_trip_w;
  logic ovc_trip_w;

  evs_tick #(.STEP_CYCLES(STEP_CYCLES)) u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  evs_delay u_volt_dly (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(tick),
    .start(volt_start),
    .delay(cfg_reg.volt_delay),
    .trip(volt_trip_w)
  );

  evs_delay u_ovc_dly (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(tick),
    .start(ovc_w),
    .delay(cfg_reg.ovc_delay),
    .trip(ovc_trip_w)
  );

  // Once failure is confirmed, stay in field current regulation until reset:
  // a silent return to voltage regulation on a bad measurement is unsafe.
  logic field_mode_latch_reg;
  wire logic field_mode_next = field_mode_latch_reg || volt_trip_w;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      field_mode_latch_reg <= 1'b0;
      voltage_regulation_mode <= 1'b1;
      field_current_regulation_mode <= 1'b0;
      meas_volt_low <= 1'b0;
      supply_volt_low <= 1'b0;
      phase_loss <= 1'b0;
      grid_disturbance <= 1'b0;
      volt_trip <= 1'b0;
      ovc_detect <= 1'b0;
      ovc_trip <= 1'b0;
      positive_sequence_gen_voltage <= '0;
      negative_sequence_gen_voltage <= '0;
      supply_volt_disp <= '0;
      cfg_active <= '0;
    end else begin
      field_mode_latch_reg <= field_mode_next;
      voltage_regulation_mode <= !field_mode_next;
      field_current_regulation_mode <= field_mode_next;
      meas_volt_low <= meas_low_w;
      supply_volt_low <= supply_low_w;
      phase_loss <= phase_loss_w;
      grid_disturbance <= disturb_w;
      volt_trip <= volt_trip_w;
      ovc_detect <= ovc_w;
      ovc_trip <= ovc_trip_w && ovc_en_reg;
      positive_sequence_gen_voltage <= meas.pos_volt;
      negative_sequence_gen_voltage <= meas.neg_volt;
      supply_volt_disp <= meas.supply_volt;
      cfg_active <= cfg_reg;
    end
  end
endmodule : evs_supervision

// file: evs_front.sv
/*
  Partner model: measurement front end that feeds the supervision block.
  Assumes the bench hands it ideal measurements; LAT sets its pipeline depth.
*/
`timescale 1ns/1ps
module evs_front
  import evs_pkg::*;
#(
  parameter int LAT = 1
) (
  input wire logic sys_clk,
  input wire evs_meas_type meas_req,
  output evs_meas_type meas
);
  evs_meas_type pipe_reg [LAT];
  // A deeper pipe models a slow converter; values only move on clock edges
  always_ff @(posedge sys_clk) begin
    pipe_reg[0] <= meas_req;
    for (int i = 1; i < LAT; i++) pipe_reg[i] <= pipe_reg[i-1];
  end
  assign meas = pipe_reg[LAT-1];
endmodule : evs_front

// file: evs_supervision_chk.sv
/*
  Port-level checker for evs_supervision.
  Assumes one clock, synchronous active-low reset; bound to every instance.
*/
`timescale 1ns/1ps
module evs_supervision_chk
  import evs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire evs_meas_type meas,
  input wire logic field_limiter_active,
  input wire logic voltage_regulation_mode,
  input wire logic field_current_regulation_mode,
  input wire logic meas_volt_low,
  input wire logic supply_volt_low,
  input wire logic phase_loss,
  input wire logic grid_disturbance,
  input wire logic volt_trip,
  input wire logic ovc_detect,
  input wire logic ovc_trip,
  input wire logic signed [EVS_PU_W-1:0] positive_sequence_gen_voltage,
  input wire evs_cfg_type cfg_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_trip_forces_change: assert property (volt_trip |->
    field_current_regulation_mode && !voltage_regulation_mode)
    else $error("trip without changeover");
  a_modes_exclusive: assert property (voltage_regulation_mode ^
    field_current_regulation_mode)
    else $error("regulation modes clash");
  a_field_mode_held: assert property (field_current_regulation_mode |=>
    field_current_regulation_mode)
    else $error("changeover dropped");
  a_phase_loss_ratio: assert property (phase_loss |->
    2 * $past(meas.neg_volt) > $past(meas.pos_volt))
    else $error("phase loss false");
  a_disturb_blocks: assert property (grid_disturbance |->
    !meas_volt_low && !supply_volt_low)
    else $error("low flag while blocked");
  // No low flag means the timer saw no start, so no trip may follow
  a_trip_holds_cond: assert property (!meas_volt_low &&
    !supply_volt_low |=> !volt_trip)
    else $error("trip outlived condition");
  a_ovc_needs_limit: assert property (ovc_detect |->
    $past(field_limiter_active))
    else $error("overcurrent without limiter");
  a_ovc_after_detect: assert property ($rose(ovc_trip) |->
    $past(ovc_detect))
    else $error("overcurrent trip without detect");
  a_ovc_disabled: assert property (!cfg_active.ovc_enable &&
    !$past(cfg_active.ovc_enable) |-> !ovc_trip)
    else $error("trip while off");
  a_display_copy: assert property ($past(rst_n) |->
    positive_sequence_gen_voltage == $past(meas.pos_volt))
    else $error("display stale");
endmodule : evs_supervision_chk

bind evs_supervision evs_supervision_chk chk (.sys_clk(sys_clk),
  .rst_n(rst_n), .meas(meas), .field_limiter_active(field_limiter_active),
  .voltage_regulation_mode(voltage_regulation_mode),
  .field_current_regulation_mode(field_current_regulation_mode),
  .meas_volt_low(meas_volt_low), .supply_volt_low(supply_volt_low),
  .phase_loss(phase_loss), .grid_disturbance(grid_disturbance),
  .volt_trip(volt_trip), .ovc_detect(ovc_detect), .ovc_trip(ovc_trip),
  .positive_sequence_gen_voltage(positive_sequence_gen_voltage),
  .cfg_active(cfg_active));

// file: testbench.sv
/*
  Self-checking bench for evs_supervision with a front-end partner model.
  Assumes STEP_CYCLES shortened to 10, so default delays are 400/6000 cycles.
*/
`timescale 1ns/1ps
module testbench;
  import evs_pkg::*;
  localparam logic [8:0] F_VR = 9'h100, F_FRM = 9'h080, F_PL = 9'h040;
  localparam logic [8:0] F_GD = 9'h020, F_MVL = 9'h010, F_SVL = 9'h008;
  localparam logic [8:0] F_VT = 9'h004, F_OD = 9'h002, F_OT = 9'h001;
  localparam logic [8:0] F_LOW = F_PL | F_GD | F_MVL | F_SVL;
  logic sys_clk, rst_n, volt_synced, on_grid, field_limiter_active;
  logic cfg_load, chk_req, vr, frm, mvl, svl, pl, gd, vt, od, ot;
  logic signed [EVS_CTRL_W:0] ctrl_signal;
  logic signed [EVS_PU_W-1:0] psv_disp, nsv_disp, sup_disp, psv;
  evs_meas_type meas_req, meas;
  evs_cfg_type cfg, cfg_active;
  logic [17:0] flag_q[$], disp_q[$], note;
  int bad_count = 0, num_checks = 0, seed = 40316;

  evs_front #(.LAT(1)) front (.sys_clk(sys_clk), .meas_req(meas_req),
    .meas(meas));
  evs_supervision #(.STEP_CYCLES(10)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .meas(meas), .ctrl_signal(ctrl_signal), .volt_synced(volt_synced),
    .on_grid(on_grid), .field_limiter_active(field_limiter_active),
    .cfg(cfg), .cfg_load(cfg_load), .voltage_regulation_mode(vr),
    .field_current_regulation_mode(frm), .meas_volt_low(mvl),
    .supply_volt_low(svl), .phase_loss(pl), .grid_disturbance(gd),
    .volt_trip(vt), .ovc_detect(od), .ovc_trip(ot),
    .positive_sequence_gen_voltage(psv_disp),
    .negative_sequence_gen_voltage(nsv_disp), .supply_volt_disp(sup_disp),
    .cfg_active(cfg_active));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic cmp_val(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_flags(input logic [8:0] got, input logic [17:0] n);
    num_checks++;
    if ((got & n[17:9]) !== n[8:0]) begin
      bad_count++;
      $display("CHECK FAILED %0t flags %b expected %b", $time, got, n[8:0]);
    end
  endtask : cmp_flags

  // Monitor: every strobe yields one result, matched to the oldest note
  always @(posedge sys_clk) begin
    if (chk_req === 1'b1) begin
      note = flag_q.pop_front();
      cmp_flags({vr, frm, pl, gd, mvl, svl, vt, od, ot}, note);
      note = disp_q.pop_front();
      cmp_val(psv_disp, note);
      note = disp_q.pop_front();
      cmp_val(nsv_disp, note);
      note = disp_q.pop_front();
      cmp_val(sup_disp, note);
    end
  end

  task automatic apply(input int a, b, c, d, e, f);
    @(posedge sys_clk);
    meas_req <= '{18'(a), 18'(b), 18'(c), 18'(d), 18'(e), 18'(f)};
  endtask : apply

  task automatic chk(input int n, input logic [8:0] m, input logic [8:0] e);
    repeat (n) @(posedge sys_clk);
    flag_q.push_back({m, e});
    disp_q.push_back(meas_req.pos_volt);
    disp_q.push_back(meas_req.neg_volt);
    disp_q.push_back(meas_req.supply_volt);
    chk_req <= 1'b1;
    @(posedge sys_clk);
    chk_req <= 1'b0;
  endtask : chk

  task automatic healthy();
    psv = 18'sd200 + 18'($random(seed) & 63);
    apply(psv, 0, 200, 0, psv, 0);
    chk(4, F_LOW | F_VT, 9'h000);
  endtask : healthy

  task automatic load_cfg();
    @(posedge sys_clk);
    cfg_load <= 1'b1;
    @(posedge sys_clk);
    cfg_load <= 1'b0;
  endtask : load_cfg

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0; volt_synced = 1'b0; on_grid = 1'b0; chk_req = 1'b0;
    field_limiter_active = 1'b0; cfg_load = 1'b0; ctrl_signal = 13'sh0c8;
    meas_req = '{18'sd200, 18'sd0, 18'sd200, 18'sd0, 18'sd200, 18'sd0};
    cfg = '{1'b1, EVS_VOLT_DLY_DEF, EVS_VOLT_RATIO_DEF, EVS_CURR_RATIO_DEF,
      EVS_FIELD_LEVEL_DEF, 1'b0, EVS_SHORT_THR_DEF, EVS_OVC_DLY_DEF};
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cmp_val(18'({cfg_active.supv_enable, cfg_active.ovc_enable}), 18'h2);
    cmp_val(18'(cfg_active.volt_delay), 18'h28);
    cmp_val(18'(cfg_active.volt_high_ratio), 18'h3c);
    cmp_val(18'(cfg_active.curr_low_ratio), 18'h3c);
    cmp_val(18'(cfg_active.field_level), 18'hc8);
    cmp_val(18'(cfg_active.short_thr), 18'h64);
    cmp_val(18'(cfg_active.ovc_delay), 18'h258);
    repeat (3) healthy();
    apply(200, 120, 200, 0, 200, 0);
    chk(4, F_LOW, F_PL | F_MVL);
    apply(200, 100, 200, 0, 200, 0);
    chk(4, F_LOW, 9'h000);
    volt_synced <= 1'b1;
    apply(200, 80, 200, 0, 200, 0);
    chk(4, F_LOW, F_MVL);
    apply(200, 80, 200, 80, 200, 0);
    chk(4, F_LOW, 9'h000);
    // Current ratio not low, but positive current under 0.1 pu
    apply(200, 80, 10, 4, 200, 0);
    chk(4, F_LOW, F_MVL);
    volt_synced <= 1'b0;
    apply(200, 120, 200, 120, 200, 0);
    chk(4, F_GD | F_MVL, F_GD);
    apply(10, 0, 0, 0, 10, 300);
    chk(4, F_LOW, F_MVL);
    apply(10, 0, 0, 0, 10, 200);
    chk(4, F_LOW, 9'h000);
    on_grid <= 1'b1;
    apply(200, 0, 200, 0, 100, 0);
    chk(4, F_LOW, F_SVL);
    apply(200, 0, 200, 0, 160, 0);
    chk(4, F_LOW, 9'h000);
    apply(200, 0, 200, 0, 300, 0);
    chk(4, F_LOW, F_MVL);
    on_grid <= 1'b0;
    chk(4, F_LOW, 9'h000);
    cfg.supv_enable <= 1'b0;
    load_cfg();
    apply(200, 120, 200, 0, 200, 0);
    chk(4, F_MVL | F_SVL, 9'h000);
    cfg.supv_enable <= 1'b1;
    load_cfg();
    healthy();
    apply(200, 120, 200, 0, 200, 0);
    chk(300, F_VT, 9'h000);
    healthy();
    apply(200, 120, 200, 0, 200, 0);
    chk(390, F_VT | F_FRM, 9'h000);
    chk(30, F_VT | F_FRM | F_VR, F_VT | F_FRM);
    healthy();
    chk(2, F_FRM | F_VR, F_FRM);
    cfg.ovc_enable <= 1'b1;
    load_cfg();
    field_limiter_active <= 1'b1;
    chk(4, F_OD, 9'h000);
    ctrl_signal <= 13'sh032;
    field_limiter_active <= 1'b0;
    chk(4, F_OD, 9'h000);
    field_limiter_active <= 1'b1;
    chk(4, F_OD | F_OT, F_OD);
    chk(5985, F_OT, 9'h000);
    chk(40, F_OD | F_OT, F_OD | F_OT);
    cfg.ovc_enable <= 1'b0;
    load_cfg();
    chk(4, F_OD | F_OT, 9'h000);
    // A zero delay trips on the cycle after the start is seen
    cfg.volt_delay <= 12'h000;
    load_cfg();
    apply(200, 120, 200, 0, 200, 0);
    chk(4, F_VT, F_VT);
    healthy();
    wrap_up();
  end
endmodule : testbench
